// *** rtq_replay_tag.sv ***
/*
 * Replay tagging and event qualification block: tags retiring micro-ops for
 * replay-based precise metrics, counts tagged non-speculative replays, and
 * reports the qualification class of non-retirement event-mask bits.
 * Assumes an Avalon-MM master on the register port and retirement inputs
 * synchronous to clk; one clock, no interrupts.
 */
// Added by the designer: the register addresses and the Avalon-MM slave port.
// Notes on behaviour
// R1: io, uncacheable, locked, return and far-transfer micro-ops are never tagged.
// R2: second-level load misses count only when the fast detection path flagged them.
// R3: forwarding replays count only when load data is not an aligned subset of a store.
// R4: tagged metrics count through the replay event with the non-speculative mask only.
// R5: each non-retirement mask bit has a fixed thread-specific or thread-independent class.
// R6: software sets enable and vertical bits, then auxiliary selections, before running.
`timescale 1ns/1ps
`include "rtq_defs.svh"

module rtq_replay_tag
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic uop_valid,
    input wire logic uop_bogus,
    input wire logic uop_is_load,
    input wire logic uop_is_store,
    input wire logic uop_is_branch,
    input wire logic uop_no_tag,
    input wire logic uop_l1_miss,
    input wire logic uop_l2_fast_miss,
    input wire logic uop_dtlb_miss,
    input wire logic uop_mispred,
    input wire logic uop_fwd_misalign,
    input wire logic uop_split,
    output logic uop_tagged,
    output logic [31:0] tag_count
);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [31:0] pse_q;
    logic [31:0] vert_q;
    logic [31:0] esel_q;
    logic [31:0] aux0_q;
    logic [31:0] aux1_q;
    logic [31:0] count_q;
    logic run_q;
    logic [3:0] qsel_q;
    logic [15:0] class_q;
    logic qvalid_q;
    logic tag_q;
    rtq_pkg::rtq_bus_state_t bus_q;
    logic wr_go;
    logic rd_go;
    logic tag_d;
    logic count_en;
    logic [15:0] class_bits;
    logic valid_bits;

    // select field and one mask bit of an event selection word
    function automatic logic evsel_is(input logic [31:0] w, input logic [6:0] sel);
        evsel_is = (w[`RTQ_SEL_HI:`RTQ_SEL_LO] == sel);
    endfunction : evsel_is

    function automatic logic mask_bit(input logic [31:0] w, input int b);
        logic [15:0] m;
        m = w[`RTQ_MASK_HI:`RTQ_MASK_LO];
        mask_bit = m[b];
    endfunction : mask_bit

    // ------------------------------------------------------------------
    // bus slave: one wait cycle on every access, answer in the next
    // ------------------------------------------------------------------
    assign wr_go = avs_write && (bus_q == rtq_pkg::RTQ_BUS_RESP);
    assign rd_go = avs_read && (bus_q == rtq_pkg::RTQ_BUS_RESP);
    assign avs_waitrequest = (avs_read || avs_write) && (bus_q != rtq_pkg::RTQ_BUS_RESP);

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            bus_q <= rtq_pkg::RTQ_BUS_IDLE;
        else
        begin
            case (bus_q)
                rtq_pkg::RTQ_BUS_IDLE:
                    if (avs_read || avs_write)
                        bus_q <= rtq_pkg::RTQ_BUS_RESP;
                rtq_pkg::RTQ_BUS_RESP: bus_q <= rtq_pkg::RTQ_BUS_IDLE;
                default: bus_q <= rtq_pkg::RTQ_BUS_IDLE;
            endcase
        end
    end

    // readback is registered while waitrequest is still high
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            avs_readdata <= `RTQ_RESET_WORD;
        else if (avs_read && bus_q == rtq_pkg::RTQ_BUS_IDLE)
        begin
            case (avs_address)
                `RTQ_OFF_PSE: avs_readdata <= pse_q;
                `RTQ_OFF_VERT: avs_readdata <= vert_q;
                `RTQ_OFF_ESEL: avs_readdata <= esel_q;
                `RTQ_OFF_AUX0: avs_readdata <= aux0_q;
                `RTQ_OFF_AUX1: avs_readdata <= aux1_q;
                `RTQ_OFF_COUNT: avs_readdata <= count_q;
                `RTQ_OFF_CTRL: avs_readdata <= {31'h0000_0000, run_q};
                `RTQ_OFF_CLASS: avs_readdata <= {15'h0000, qvalid_q, class_q};
                `RTQ_OFF_QSEL: avs_readdata <= {28'h000_0000, qsel_q};
                default: avs_readdata <= `RTQ_RESET_WORD; // unmapped reads zero
            endcase
        end
    end

    // configuration writes; the run bit is what starts counting
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pse_q <= `RTQ_RESET_WORD;
            vert_q <= `RTQ_RESET_WORD;
            esel_q <= `RTQ_RESET_WORD;
            aux0_q <= `RTQ_RESET_WORD;
            aux1_q <= `RTQ_RESET_WORD;
            run_q <= 1'b0;
            qsel_q <= 4'h0;
        end
        else if (wr_go)
        begin
            case (avs_address)
                `RTQ_OFF_PSE: pse_q <= avs_writedata;
                `RTQ_OFF_VERT: vert_q <= avs_writedata;
                `RTQ_OFF_ESEL: esel_q <= avs_writedata;
                `RTQ_OFF_AUX0: aux0_q <= avs_writedata;
                `RTQ_OFF_AUX1: aux1_q <= avs_writedata;
                `RTQ_OFF_CTRL: run_q <= avs_writedata[`RTQ_CTRL_RUN];
                `RTQ_OFF_QSEL: qsel_q <= avs_writedata[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // tagging decision for one retiring micro-op
    // ------------------------------------------------------------------
    // enable pair at 24/25 gates everything; each metric also needs its
    // vertical select so loads and stores are told apart
    always_comb
    begin
        logic en;
        logic ld;
        logic st;
        en = 1'b0;
        ld = 1'b0;
        st = 1'b0;
        en = pse_q[`RTQ_PSE_EN0] && pse_q[`RTQ_PSE_EN1]; // R6
        ld = uop_is_load && vert_q[`RTQ_VERT_LOAD];
        st = uop_is_store && vert_q[`RTQ_VERT_STORE];
        tag_d = 1'b0;
        if (ld && pse_q[`RTQ_PSE_L1] && uop_l1_miss)
            tag_d = 1'b1;
        if (ld && pse_q[`RTQ_PSE_L2] && uop_l2_fast_miss) // R2
            tag_d = 1'b1;
        if ((ld || st) && pse_q[`RTQ_PSE_DTLB] && uop_dtlb_miss)
            tag_d = 1'b1;
        if (uop_is_branch && vert_q[`RTQ_VERT_BRANCH] && pse_q[`RTQ_PSE_BR0]
            && pse_q[`RTQ_PSE_BR1] && uop_mispred)
            tag_d = 1'b1;
        if (ld && pse_q[`RTQ_PSE_FWD] && uop_fwd_misalign // R3
            && evsel_is(aux0_q, `RTQ_EVSEL_MOBLD)
            && mask_bit(aux0_q, `RTQ_MASK_PARTIAL) && mask_bit(aux0_q, `RTQ_MASK_UNALGN))
            tag_d = 1'b1;
        if (ld && pse_q[`RTQ_PSE_SPLIT] && uop_split
            && evsel_is(aux1_q, `RTQ_EVSEL_LDPORT) && mask_bit(aux1_q, `RTQ_MASK_SPLIT))
            tag_d = 1'b1;
        if (st && pse_q[`RTQ_PSE_SPLIT] && uop_split
            && evsel_is(aux0_q, `RTQ_EVSEL_STPORT) && mask_bit(aux0_q, `RTQ_MASK_SPLIT))
            tag_d = 1'b1;
        tag_d = tag_d && en && uop_valid && !uop_no_tag; // R1
    end

    // counting only through the replay event with the non-bogus mask
    assign count_en = run_q && tag_q && evsel_is(esel_q, `RTQ_EVSEL_REPLAY) // R4
        && mask_bit(esel_q, `RTQ_MASK_NONSPEC);

    // tag and bogus flag staged together so the count sees a matching pair
    logic bogus_q;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            tag_q <= 1'b0;
            bogus_q <= 1'b0;
        end
        else
        begin
            tag_q <= tag_d;
            bogus_q <= uop_bogus;
        end
    end

    // counter; a clear write loses to nothing but itself, a bogus uop never counts
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            count_q <= `RTQ_RESET_WORD;
        else if (wr_go && avs_address == `RTQ_OFF_CTRL && avs_writedata[`RTQ_CTRL_CLEAR])
            count_q <= `RTQ_RESET_WORD;
        else if (count_en && !bogus_q) // R4
            count_q <= count_q + 32'h0000_0001;
    end

    // ------------------------------------------------------------------
    // qualification class lookup, registered for readback
    // ------------------------------------------------------------------
    rtq_qualify u_qualify
    (
        .event_sel(qsel_q),
        .class_bits(class_bits),
        .valid_bits(valid_bits)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            class_q <= 16'h0000;
            qvalid_q <= 1'b0;
        end
        else
        begin
            class_q <= class_bits; // R5
            qvalid_q <= valid_bits;
        end
    end

    assign uop_tagged = tag_q;
    assign tag_count = count_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    no_tag_excl_a: assert property (@(posedge clk) disable iff (!reset_n) // R1
        uop_no_tag |=> !uop_tagged) else $error("excluded uop was tagged");
    l2_fast_only_a: assert property (@(posedge clk) disable iff (!reset_n) // R2
        (uop_valid && !uop_l1_miss && !uop_l2_fast_miss && !uop_dtlb_miss && !uop_mispred
         && !uop_fwd_misalign && !uop_split) |=> !uop_tagged)
        else $error("uop tagged without any flagged cause");
    fwd_needs_mask_a: assert property (@(posedge clk) disable iff (!reset_n) // R3
        (uop_fwd_misalign && !uop_l1_miss && !uop_l2_fast_miss && !uop_dtlb_miss
         && !uop_mispred && !uop_split && !mask_bit(aux0_q, `RTQ_MASK_PARTIAL))
         |=> !uop_tagged)
        else $error("forwarding replay tagged without partial mask");
    bogus_no_count_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
        (bogus_q && !wr_go) |=> $stable(count_q)) else $error("bogus uop counted");
    count_step_a: assert property (@(posedge clk) disable iff (!reset_n) // R4
        (count_en && !bogus_q && !wr_go) |=> (count_q == $past(count_q) + 32'h0000_0001))
        else $error("tagged replay not counted");
    class_table_a: assert property (@(posedge clk) disable iff (!reset_n) // R5
        (qsel_q == 4'h6) [*2] |-> (class_q == 16'h0018)) else $error("moves class wrong");
    enable_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // R6
        !(pse_q[`RTQ_PSE_EN0] && pse_q[`RTQ_PSE_EN1]) |=> !uop_tagged)
        else $error("tag without enable pair");
    bus_wait_a: assert property (@(posedge clk) disable iff (!reset_n)
        ($rose(avs_read) && bus_q == rtq_pkg::RTQ_BUS_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("read answer not in one wait cycle");

    tag_seen_c: cover property (@(posedge clk) disable iff (!reset_n) uop_tagged);
    count_seen_c: cover property (@(posedge clk) disable iff (!reset_n) count_en && !bogus_q);
    write_seen_c: cover property (@(posedge clk) disable iff (!reset_n) wr_go);

endmodule : rtq_replay_tag

// *** rtq_defs.svh ***
/*
 * Register offsets, field positions, reset values and encodings for the replay
 * tagging and event qualification block.
 * Assumes a 32-bit Avalon-MM slave with a 6-bit byte address, word aligned.
 */
`ifndef RTQ_DEFS_SVH
`define RTQ_DEFS_SVH

// ------------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------------
`define RTQ_OFF_PSE      6'h00
`define RTQ_OFF_VERT     6'h04
`define RTQ_OFF_ESEL     6'h08
`define RTQ_OFF_AUX0     6'h0C
`define RTQ_OFF_AUX1     6'h10
`define RTQ_OFF_COUNT    6'h14
`define RTQ_OFF_CTRL     6'h18
`define RTQ_OFF_CLASS    6'h1C
`define RTQ_OFF_QSEL     6'h20

// ------------------------------------------------------------------
// precise-sample enable fields
// ------------------------------------------------------------------
`define RTQ_PSE_L1       0
`define RTQ_PSE_L2       1
`define RTQ_PSE_DTLB     2
`define RTQ_PSE_FWD      9
`define RTQ_PSE_SPLIT    10
`define RTQ_PSE_BR0      15
`define RTQ_PSE_BR1      16
`define RTQ_PSE_EN0      24
`define RTQ_PSE_EN1      25

// ------------------------------------------------------------------
// vertical matrix fields
// ------------------------------------------------------------------
`define RTQ_VERT_LOAD    0
`define RTQ_VERT_STORE   1
`define RTQ_VERT_BRANCH  4

// ------------------------------------------------------------------
// event select fields: select in [31:25], mask in [24:9]
// ------------------------------------------------------------------
`define RTQ_SEL_HI       31
`define RTQ_SEL_LO       25
`define RTQ_MASK_HI      24
`define RTQ_MASK_LO      9
`define RTQ_MASK_NONSPEC 0
`define RTQ_MASK_BOGUS   1
`define RTQ_MASK_PARTIAL 4
`define RTQ_MASK_UNALGN  5
`define RTQ_MASK_SPLIT   1
`define RTQ_EVSEL_REPLAY 7'h09
`define RTQ_EVSEL_MOBLD  7'h03
`define RTQ_EVSEL_LDPORT 7'h04
`define RTQ_EVSEL_STPORT 7'h05

`define RTQ_RESET_WORD   32'h0000_0000
`define RTQ_CTRL_RUN     0
`define RTQ_CTRL_CLEAR   1

`endif

// *** rtq_pkg.sv ***
/*
 * Types shared by the replay tagging block.
 * Assumes rtq_defs.svh for the numeric constants.
 */
package rtq_pkg;

    // ------------------------------------------------------------------
    // qualification class of one event-mask bit
    // ------------------------------------------------------------------
    typedef enum logic [0:0] {
        RTQ_CLASS_THREAD_SPECIFIC = 1'b0,
        RTQ_CLASS_THREAD_INDEPENDENT = 1'b1
    } rtq_class_t;

    // ------------------------------------------------------------------
    // bus slave state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        RTQ_BUS_IDLE = 2'b00,
        RTQ_BUS_RESP = 2'b01
    } rtq_bus_state_t;

    // ------------------------------------------------------------------
    // non-retirement event selections with a qualification table
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        RTQ_EV_BPU_FETCH = 4'h0,
        RTQ_EV_BSQ_ALLOC = 4'h1,
        RTQ_EV_BSQ_CACHE = 4'h2,
        RTQ_EV_MEM_CANCEL = 4'h3,
        RTQ_EV_SSE_ASSIST = 4'h4,
        RTQ_EV_SIMD_UOPS = 4'h5,
        RTQ_EV_SIMD_MOVES = 4'h6,
        RTQ_EV_BUS_DATA = 4'h7,
        RTQ_EV_IOQ_ALLOC = 4'h8
    } rtq_event_t;

endpackage : rtq_pkg

// *** rtq_qualify.sv ***
/*
 * Qualification class table: for a chosen non-retirement event, gives the
 * class of each of its sixteen event-mask bits.
 * Assumes the caller registers the result; purely combinational.
 */
`timescale 1ns/1ps
`include "rtq_defs.svh"

module rtq_qualify
(
    input wire logic [3:0] event_sel,
    output logic [15:0] class_bits,
    output logic valid_bits
);

    // ------------------------------------------------------------------
    // table lookup, bit set = thread-independent, clear = thread-specific
    // ------------------------------------------------------------------
    // unlisted events fall back to thread-specific with valid low
    always_comb
    begin
        class_bits = 16'h0000; // R5
        valid_bits = 1'b1;
        case (rtq_pkg::rtq_event_t'(event_sel))
            rtq_pkg::RTQ_EV_BPU_FETCH: class_bits = 16'h0000;
            rtq_pkg::RTQ_EV_BSQ_ALLOC: class_bits = 16'h0000;
            rtq_pkg::RTQ_EV_BSQ_CACHE: class_bits = 16'h0000;
            rtq_pkg::RTQ_EV_MEM_CANCEL: class_bits = 16'h0000;
            rtq_pkg::RTQ_EV_SSE_ASSIST: class_bits = 16'h8000; // R5
            rtq_pkg::RTQ_EV_SIMD_UOPS: class_bits = 16'h8000;
            rtq_pkg::RTQ_EV_SIMD_MOVES: class_bits = 16'h0018; // R5
            rtq_pkg::RTQ_EV_BUS_DATA: class_bits = 16'h003F;
            rtq_pkg::RTQ_EV_IOQ_ALLOC: class_bits = 16'h0000;
            default: valid_bits = 1'b0;
        endcase
    end

endmodule : rtq_qualify

// *** test_rtq_replay_tag.sv ***
/*
 * Self-checking bench for the replay tagging block: register access over
 * Avalon-MM, the class table, and the retirement tagging and count path.
 * Assumes rtq_defs.svh offsets and the one-wait-cycle slave of the design.
 */
`timescale 1ns/1ps
`include "rtq_defs.svh"

module test_rtq_replay_tag;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [10:0] uf = 11'h000;
    logic uop_valid = 1'b0;
    logic uop_tagged;
    logic [31:0] tag_count;
    logic [31:0] rd;
    logic [31:0] cnt;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    localparam logic [31:0] CLS [0:9] = '{32'h0001_0000, 32'h0001_0000, 32'h0001_0000,
        32'h0001_0000, 32'h0001_8000, 32'h0001_8000, 32'h0001_0018, 32'h0001_003F,
        32'h0001_0000, 32'h0000_0000};

    // ------------------------------------------------------------------
    // device under test
    // ------------------------------------------------------------------
    rtq_replay_tag u_rtq_replay_tag
    (
        .clk(clk),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .uop_valid(uop_valid),
        .uop_bogus(uf[10]),
        .uop_is_load(uf[9]),
        .uop_is_store(uf[8]),
        .uop_is_branch(uf[7]),
        .uop_no_tag(uf[6]),
        .uop_l1_miss(uf[5]),
        .uop_l2_fast_miss(uf[4]),
        .uop_dtlb_miss(uf[3]),
        .uop_mispred(uf[2]),
        .uop_fwd_misalign(uf[1]),
        .uop_split(uf[0]),
        .uop_tagged(uop_tagged),
        .tag_count(tag_count)
    );

    // free-running 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            bad_count = bad_count + 1;
            end_of_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one bus transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] addr, input logic [31:0] data);
        @(posedge clk);
        avs_address <= addr;
        avs_writedata <= data;
        avs_read <= ~wr;
        avs_write <= wr;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rchk(input logic [5:0] addr, input logic [31:0] exp);
        bus(1'b0, addr, 32'h0000_0000);
        chk("readdata", exp, rd);
    endtask : rchk

    // one retiring micro-op; tag seen a cycle later, count a cycle after that
    task automatic uop(input logic [10:0] f, input logic exp_tag, input logic counts);
        @(posedge clk);
        uf <= f;
        uop_valid <= 1'b1;
        @(posedge clk);
        uop_valid <= 1'b0;
        uf <= 11'h000;
        #1;
        if (exp_tag !== 1'bx)
            chk("uop_tagged", {31'h0, exp_tag}, {31'h0, uop_tagged});
        cnt = cnt + (counts ? 32'h1 : 32'h0);
        @(posedge clk);
        #1;
        chk("tag_count", cnt, tag_count);
    endtask : uop

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        cnt = 32'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        // PSE, ESEL and COUNT idle at zero, unmapped places read zero and ignore writes
        rchk(`RTQ_OFF_PSE, `RTQ_RESET_WORD);
        rchk(`RTQ_OFF_ESEL, `RTQ_RESET_WORD);
        rchk(`RTQ_OFF_COUNT, `RTQ_RESET_WORD);
        bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
        rchk(6'h3C, 32'h0000_0000);
        // class table for query codes 0 to 8, one invalid code (9) last
        for (int k = 0; k < 10; k++)
        begin
            bus(1'b1, `RTQ_OFF_QSEL, 32'(k));
            rchk(`RTQ_OFF_CLASS, CLS[k]);
        end
        rchk(`RTQ_OFF_QSEL, 32'h0000_0009);
        // enable bits, vertical selects, replay event with the non-speculative mask
        bus(1'b1, `RTQ_OFF_PSE, 32'h0301_8607);
        rchk(`RTQ_OFF_PSE, 32'h0301_8607);
        bus(1'b1, `RTQ_OFF_VERT, 32'h0000_0013);
        bus(1'b1, `RTQ_OFF_ESEL, 32'h1200_0200);
        bus(1'b1, `RTQ_OFF_AUX0, 32'h0600_6000);
        bus(1'b1, `RTQ_OFF_AUX1, 32'h0800_0400);
        // vertical and auxiliary configuration words read back as written
        rchk(`RTQ_OFF_VERT, 32'h0000_0013);
        rchk(`RTQ_OFF_AUX0, 32'h0600_6000);
        rchk(`RTQ_OFF_AUX1, 32'h0800_0400);
        bus(1'b1, `RTQ_OFF_CTRL, 32'h0000_0001);
        uop(11'h220, 1'b1, 1'b1);
        uop(11'h260, 1'b0, 1'b0);
        uop(11'h0C4, 1'b0, 1'b0);
        uop(11'h210, 1'b1, 1'b1);
        uop(11'h200, 1'b0, 1'b0);
        uop(11'h208, 1'b1, 1'b1);
        uop(11'h108, 1'b1, 1'b1);
        uop(11'h084, 1'b1, 1'b1);
        uop(11'h202, 1'b1, 1'b1);
        uop(11'h201, 1'b1, 1'b1);
        uop(11'h620, 1'b1, 1'b0);
        // store-port split replays share the first auxiliary select
        bus(1'b1, `RTQ_OFF_AUX0, 32'h0A00_0400);
        uop(11'h101, 1'b1, 1'b1);
        uop(11'h202, 1'b0, 1'b0);
        rchk(`RTQ_OFF_COUNT, cnt);
        // bogus-only mask: tags still retire but nothing is counted
        bus(1'b1, `RTQ_OFF_ESEL, 32'h1200_0400);
        uop(11'h220, 1'b1, 1'b0);
        bus(1'b1, `RTQ_OFF_ESEL, 32'h1200_0200);
        // losing the store vertical select or a global enable stops tagging
        bus(1'b1, `RTQ_OFF_VERT, 32'h0000_0011);
        uop(11'h108, 1'b0, 1'b0);
        bus(1'b1, `RTQ_OFF_PSE, 32'h0101_8607);
        uop(11'h220, 1'b0, 1'b0);
        // clear pulse zeroes the count while run stays set
        bus(1'b1, `RTQ_OFF_CTRL, 32'h0000_0003);
        cnt = 32'h0;
        rchk(`RTQ_OFF_COUNT, cnt);
        // clear is a pulse: only the run bit reads back
        rchk(`RTQ_OFF_CTRL, 32'h0000_0001);
        end_of_test();
    end

endmodule : test_rtq_replay_tag
